// *** bench/host_mcu.sv ***
// Host microcontroller model on the non-multiplexed register bus
`timescale 1ns/1ns
`include "ram_port_params.svh"
module host_mcu
   import ram_port_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register bus
   output host_req_t host_req,
   input wire logic [7:0] host_rdata
);
   initial host_req = '0;
   // One strobe cycle, then a gap long enough for a half-speed prefetch
   task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      host_req <= '{rd: rd, wr: !rd, addr: a, wdata: v};
      @(posedge clk);
      host_req <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: ~v}; // Released lines do not hold
      repeat (8) @(posedge clk);
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      access(1'b1, a, 8'h00);
      d = host_rdata;
   endtask
   // High byte first; the low byte latches the whole pointer
   task automatic load_ptr(input logic inc, input logic [10:0] p);
      access(1'b0, `OFS_PTR_HIGH, {inc, 4'h0, p[10:8]});
      access(1'b0, `OFS_PTR_LOW, p[7:0]);
   endtask
endmodule

// *** bench/seq_ram_port_checker.sv ***
// Concurrent checks on the sequential RAM access port
`timescale 1ns/1ns
module seq_ram_port_checker
   import ram_port_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Host and setup inputs
   input wire host_req_t host_req,
   input wire logic [7:0] setup_wdata,
   input wire logic setup_we,
   // Outputs watched
   input wire logic [7:0] host_rdata,
   input wire setup_t setup_out,
   input wire logic fast_read_out,
   input wire logic init_done,
   input wire logic reconfig_timeout,
   input wire logic busy
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire set_go = setup_we && clk_en;
   wire ld_go = clk_en && host_req.wr && host_req.addr == 3'h3;
   property p_fast; set_go |=> fast_read_out == $past(setup_wdata[7]); endproperty
   a_fast: assert property (p_fast) else $error("fast read bit wrong");
   property p_enh; set_go |=> setup_out.enhanced_func_en == $past(setup_wdata[3]); endproperty
   a_enh: assert property (p_enh) else $error("enhanced bit wrong");
   property p_sync; set_go |=> setup_out.skip_line_idle_wait == $past(setup_wdata[2]); endproperty
   a_sync: assert property (p_sync) else $error("idle wait bit wrong");
   property p_tsel; set_go |=> setup_out.reconfig_timeout_sel == $past(setup_wdata[1:0]); endproperty
   a_tsel: assert property (p_tsel) else $error("timeout select wrong");
   property p_load; ld_go |=> busy; endproperty
   a_load: assert property (p_load) else $error("no prefetch after load");
   // Prefetch must finish inside the host's spacing, even at half speed
   property p_fetch; $rose(busy) |-> ##[1:7] !busy; endproperty
   a_fetch: assert property (p_fetch) else $error("prefetch too slow");
   property p_hold; !(clk_en && host_req.rd) |=> $stable(host_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unmap;
      clk_en && host_req.rd && !host_req.wr && !(host_req.addr inside {[3'h2:3'h4]})
         |=> host_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_pulse; reconfig_timeout |=> !reconfig_timeout; endproperty
   a_pulse: assert property (p_pulse) else $error("timeout not a pulse");
   c_fetch: cover property ($fell(busy));
   c_to: cover property (reconfig_timeout);
   c_init: cover property ($rose(init_done));
endmodule

bind seq_ram_port seq_ram_port_checker chk (.clk(clk), .resetn(resetn), .clk_en(clk_en),
   .host_req(host_req), .setup_wdata(setup_wdata), .setup_we(setup_we),
   .host_rdata(host_rdata), .setup_out(setup_out), .fast_read_out(fast_read_out),
   .init_done(init_done), .reconfig_timeout(reconfig_timeout), .busy(busy));

// *** bench/sequential_ram_access_port_bench.sv ***
// Self-checking bench for the sequential RAM access port
`timescale 1ns/1ns
`include "ram_port_params.svh"
module sequential_ram_access_port_bench
   import ram_port_pkg::*;
;
   `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
      $display("[ERR] %s exp %0h got %0h", n, e, g); end end
   typedef struct {logic [10:0] a; logic [7:0] v;} row_t;
   logic clk, resetn, setup_we, half_speed_arbitration, line_idle, init_req, reconfig_start;
   logic [7:0] setup_wdata, host_rdata, d;
   host_req_t host_req;
   setup_t setup_out;
   logic fast_read_out, init_done, reconfig_timeout, busy, clk_en;
   int n_mismatch = 0, comparisons = 0, cyc = 0, t0;
   int lat[4];
   row_t rows[4] = '{'{11'h000, 8'hA5}, '{11'h0FF, 8'h5A}, '{11'h100, 8'h01}, '{11'h7FF, 8'hFE}};
   seq_ram_port #(.TO_00(40), .TO_01(30), .TO_10(20), .TO_11(10)) uut (.clk, .resetn,
      .clk_en, .host_req, .host_rdata, .setup_wdata, .setup_we, .half_speed_arbitration,
      .line_idle, .init_req, .reconfig_start, .setup_out, .fast_read_out, .init_done,
      .reconfig_timeout, .busy);
   host_mcu host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));
   // ---------------------------------------------
   // Clock, watchdog and verdict
   // ---------------------------------------------
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Runaway guard, well above the roughly 7150 cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic set_setup(input logic [7:0] v);
      @(posedge clk);
      setup_we <= 1'b1;
      setup_wdata <= v;
      @(posedge clk);
      setup_we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk_rd(input string n, input logic [2:0] a, input logic [7:0] e);
      host.rd_reg(a, d);
      `CHK(n, e, d)
   endtask
   task automatic wait_init();
      t0 = 0;
      while (init_done !== 1'b1 && t0 < 4500) begin
         @(posedge clk);
         t0++;
      end
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {resetn, setup_we, half_speed_arbitration, line_idle, init_req, reconfig_start} = '0;
      setup_wdata = 8'h00;
      clk_en = 1'b1;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      #1;
      `CHK("setup_rst", 5'h00, setup_out)
      `CHK("fast_rst", 1'b0, fast_read_out)
      // Ordinary cases: write, reload before the direction change, read back
      foreach (rows[i]) begin
         host.load_ptr(1'b0, rows[i].a);
         host.access(1'b0, `OFS_DATA, rows[i].v);
         host.load_ptr(1'b0, rows[i].a);
         chk_rd("row_data", `OFS_DATA, rows[i].v);
         chk_rd("row_lo", `OFS_PTR_LOW, rows[i].a[7:0]);
         host.rd_reg(`OFS_PTR_HIGH, d);
         `CHK("row_hi", rows[i].a[10:8], d[2:0])
      end
      // Every timeout code, with the reserved bits 6:4 set
      for (int k = 0; k < 4; k++) begin
         set_setup({k[0], 3'b111, k[1], k[0], k[1:0]});
         `CHK("setup", {k[0], k[1], k[0], k[1:0]}, setup_out)
         `CHK("fast", k[0], fast_read_out)
         reconfig_start <= 1'b1;
         @(posedge clk);
         reconfig_start <= 1'b0;
         lat[k] = 0;
         // Sample just after each edge, once the flops have settled
         do begin
            @(posedge clk);
            #1;
            lat[k]++;
         end while (reconfig_timeout !== 1'b1 && lat[k] < 200);
      end
      `CHK("to_11", 10, lat[3])
      `CHK("to_00", 30, lat[0] - lat[3])
      `CHK("to_01", 20, lat[1] - lat[3])
      `CHK("to_10", 10, lat[2] - lat[3])
      // Auto-increment burst across the top of the buffer
      set_setup(8'h00);
      host.load_ptr(1'b1, 11'h7FE);
      for (int i = 1; i < 4; i++) host.access(1'b0, `OFS_DATA, 8'h11 * i);
      chk_rd("wrap_lo", `OFS_PTR_LOW, 8'h01);
      half_speed_arbitration <= 1'b1;
      host.load_ptr(1'b1, 11'h7FE);
      for (int i = 1; i < 4; i++) chk_rd("burst", `OFS_DATA, 8'h11 * i);
      chk_rd("burst_lo", `OFS_PTR_LOW, 8'h01);
      half_speed_arbitration <= 1'b0;
      // Fixed pointer: repeated reads and overwrites stay on one byte
      host.load_ptr(1'b0, 11'h7FF);
      chk_rd("fix_rd", `OFS_DATA, 8'h22);
      chk_rd("fix_rd2", `OFS_DATA, 8'h22);
      host.load_ptr(1'b0, 11'h7FF);
      host.access(1'b0, `OFS_DATA, 8'h44);
      host.access(1'b0, `OFS_DATA, 8'h55);
      host.load_ptr(1'b0, 11'h7FF);
      chk_rd("overwrite", `OFS_DATA, 8'h55);
      for (int a = 0; a < 8; a++) if (a < 2 || a > 4) chk_rd("unmapped", a[2:0], 8'h00);
      // Initialisation sweep waits for an idle line
      init_req <= 1'b1;
      @(posedge clk);
      init_req <= 1'b0;
      repeat (2200) @(posedge clk);
      `CHK("init_wait", 1'b0, init_done)
      line_idle <= 1'b1;
      wait_init();
      `CHK("init_idle", 1'b1, init_done)
      host.load_ptr(1'b0, 11'h100);
      chk_rd("swept", `OFS_DATA, 8'h00);
      host.load_ptr(1'b0, 11'h100);
      host.access(1'b0, `OFS_DATA, 8'h7F);
      // Busy line with the idle wait skipped
      line_idle <= 1'b0;
      set_setup(8'h04);
      init_req <= 1'b1;
      @(posedge clk);
      init_req <= 1'b0;
      repeat (4) @(posedge clk);
      wait_init();
      `CHK("init_skip_line_idle_wait", 1'b1, init_done)
      host.load_ptr(1'b0, 11'h100);
      chk_rd("swept2", `OFS_DATA, 8'h00);
      // Clock enable low freezes the setup register against a write
      clk_en <= 1'b0;
      set_setup(8'h8B);
      `CHK("freeze", 5'h04, setup_out)
      // Mid-run reset clears setup, sweep status and the pointer
      clk_en <= 1'b1;
      resetn <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("setup_rst2", 5'h00, setup_out)
      `CHK("init_rst2", 1'b0, init_done)
      @(posedge clk);
      resetn <= 1'b1;
      chk_rd("ptr_rst", `OFS_PTR_LOW, 8'h00);
      tally_and_finish();
   end
endmodule

// *** common/ram_port_params.svh ***
// Constants for the sequential RAM access port: offsets, fields, resets, timing
`ifndef RAM_PORT_PARAMS_SVH
`define RAM_PORT_PARAMS_SVH

// Register offsets
`define OFS_PTR_HIGH 3'h2
`define OFS_PTR_LOW 3'h3
`define OFS_DATA 3'h4

// Pointer high fields
`define PTR_HIGH_AUTOINC_BIT 7
`define PTR_HIGH_ADDR_MSB 2

// Setup register fields
`define SETUP_FAST_READ_BIT 7
`define SETUP_ENH_BIT 3
`define SETUP_SKIP_BIT 2
`define SETUP_RECONF_LSB 0
`define SETUP_RESET 8'h00
`define SETUP_WMASK 8'h8F

// Sizes
`define RAM_ADDR_W 11
`define RAM_DEPTH 2048

// Reconfiguration timeouts in microseconds at the base data rate
`define RECONF_US_00 6720000
`define RECONF_US_01 1680000
`define RECONF_US_10 840000
`define RECONF_US_11 420000
`define CLK_MHZ 25

`endif

// *** common/ram_port_pkg.sv ***
// Types shared by the sequential RAM access port
package ram_port_pkg;

   // One host bus cycle as seen by the port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   // Decoded setup register
   typedef struct packed {
      logic fast_read_timing_sel;
      logic enhanced_func_en;
      logic skip_line_idle_wait;
      logic [1:0] reconfig_timeout_sel;
   } setup_t;

   // RAM engine states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_STORE = 4'b0100,
      ST_INIT = 4'b1000
   } ram_state_t;

endpackage

// *** verilog/seq_ram_port.sv ***
// Sequential pointer-based host access to the 2K x 8 buffer RAM
`timescale 1ns/1ns
`include "ram_port_params.svh"

module seq_ram_port
   import ram_port_pkg::*;
#(
   parameter int unsigned TO_00 = `RECONF_US_00 * `CLK_MHZ,
   parameter int unsigned TO_01 = `RECONF_US_01 * `CLK_MHZ,
   parameter int unsigned TO_10 = `RECONF_US_10 * `CLK_MHZ,
   parameter int unsigned TO_11 = `RECONF_US_11 * `CLK_MHZ
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Host register access
   input wire host_req_t host_req,
   output logic [7:0] host_rdata,
   // Configuration inputs
   input wire logic [7:0] setup_wdata,
   input wire logic setup_we,
   input wire logic half_speed_arbitration,
   // Network side status and requests
   input wire logic line_idle,
   input wire logic init_req,
   input wire logic reconfig_start,
   // Status outputs
   output setup_t setup_out,
   output logic fast_read_out,
   output logic init_done,
   output logic reconfig_timeout,
   output logic busy
);

   // ----------------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------------
   // Buffer array, no reset
   logic [7:0] ram [0:`RAM_DEPTH-1];

   // Host-visible registers
   logic [7:0] setup_q, setup_d;
   logic autoinc_q, autoinc_d;
   logic [2:0] hi_q, hi_d;
   logic [`RAM_ADDR_W-1:0] ptr_q, ptr_d;
   logic [7:0] rdata_q, rdata_d;

   // Prefetch and posted-write path between the host and the buffer
   logic [7:0] hold_q, hold_d;
   logic [7:0] wbuf_q, wbuf_d;
   logic fetch_pend_q, fetch_pend_d;
   logic store_pend_q, store_pend_d;
   logic [`RAM_ADDR_W-1:0] store_addr_q, store_addr_d;

   // RAM engine and initialisation sweep
   logic arb_tick_q, arb_tick_d;
   ram_state_t st_q, st_d;
   logic init_pend_q, init_pend_d;
   logic [`RAM_ADDR_W-1:0] init_addr_q, init_addr_d;
   logic init_done_q, init_done_d;

   // Reconfiguration timer
   logic [27:0] rc_cnt_q, rc_cnt_d;
   logic rc_run_q, rc_run_d;
   logic rc_to_q, rc_to_d;
   logic [27:0] rc_limit;

   // Single buffer port, shared by stores, prefetches and the sweep
   logic ram_we;
   logic [`RAM_ADDR_W-1:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic [`RAM_ADDR_W-1:0] ram_raddr;

   // ----------------------------------------------------------------------
   // Host register decode
   // ----------------------------------------------------------------------
   // Pointer, data and setup registers; the engine runs at the arbitration tick.
   // The host never waits: a low-byte write or an auto-increment read only
   // raises a prefetch request, and a data write only parks the byte in the
   // write buffer with its address. The engine drains these on later ticks,
   // so a host that crowds its accesses closer than the prefetch time reads
   // a stale byte rather than stalling the bus. Only one access of each kind
   // can wait at a time; a second data write before the first is stored
   // replaces it.
   always_comb begin
      setup_d = setup_q;
      autoinc_d = autoinc_q;
      hi_d = hi_q;
      ptr_d = ptr_q;
      hold_d = hold_q;
      wbuf_d = wbuf_q;
      fetch_pend_d = fetch_pend_q;
      store_pend_d = store_pend_q;
      store_addr_d = store_addr_q;
      rdata_d = rdata_q;
      init_pend_d = init_pend_q || init_req;
      init_addr_d = init_addr_q;
      init_done_d = init_done_q;
      st_d = st_q;
      ram_we = 1'b0;
      ram_waddr = store_addr_q;
      ram_wdata = wbuf_q;
      ram_raddr = ptr_q;
      // Halved arbitration clock only grants RAM every other cycle
      arb_tick_d = half_speed_arbitration ? ~arb_tick_q : 1'b1;
      if (setup_we) begin
         // Reserved bits 6:4 hold no state and read as zero
         setup_d = setup_wdata & `SETUP_WMASK;
      end
      if (host_req.wr) begin
         case (host_req.addr)
            `OFS_PTR_HIGH: begin
               // Auto-increment choice travels with the high byte
               autoinc_d = host_req.wdata[`PTR_HIGH_AUTOINC_BIT];
               hi_d = host_req.wdata[`PTR_HIGH_ADDR_MSB:0];
            end
            `OFS_PTR_LOW: begin
               // Low byte write commits the whole address and starts prefetch
               ptr_d = {hi_q, host_req.wdata};
               fetch_pend_d = 1'b1;
            end
            `OFS_DATA: begin
               wbuf_d = host_req.wdata;
               store_addr_d = ptr_q;
               store_pend_d = 1'b1;
               // Pointer wraps naturally at eleven bits
               ptr_d = autoinc_q ? ptr_q + 11'h001 : ptr_q;
            end
            default: begin
            end
         endcase
      end else if (host_req.rd) begin
         case (host_req.addr)
            // Low-byte readback shows how far a burst has advanced; the high byte reads back as loaded
            `OFS_PTR_HIGH: rdata_d = {autoinc_q, 4'h0, hi_q};
            `OFS_PTR_LOW: rdata_d = ptr_q[7:0];
            `OFS_DATA: begin
               rdata_d = hold_q;
               if (autoinc_q) begin
                  ptr_d = ptr_q + 11'h001;
                  fetch_pend_d = 1'b1;
               end
            end
            default: rdata_d = 8'h00;
         endcase
      end

      // RAM engine: one access per arbitration tick. Posted writes go first
      // so that a later prefetch of the same byte sees the new value; the
      // sweep runs last and holds the port for all 2048 bytes.
      case (st_q)
         ST_IDLE: begin
            if (arb_tick_q) begin
               if (store_pend_q) begin
                  st_d = ST_STORE;
               end else if (fetch_pend_q) begin
                  st_d = ST_FETCH;
               end else if (init_pend_q &&
                            (setup_q[`SETUP_SKIP_BIT] || line_idle)) begin
                  st_d = ST_INIT;
                  init_addr_d = '0;
                  init_done_d = 1'b0;
               end
            end
         end
         ST_STORE: begin
            // A host write in this very cycle keeps a fresh store pending
            ram_we = 1'b1;
            store_pend_d = store_pend_d && !(store_pend_q && !host_req.wr);
            st_d = ST_IDLE;
         end
         ST_FETCH: begin
            // A fresh pointer load in this cycle re-arms the prefetch, same address too
            hold_d = ram[ram_raddr];
            fetch_pend_d = fetch_pend_d &&
                           (ptr_d != ptr_q || (host_req.wr && host_req.addr == `OFS_PTR_LOW));
            st_d = ST_IDLE;
         end
         ST_INIT: begin
            // One byte per cycle; queued host accesses wait until the sweep ends
            ram_we = 1'b1;
            ram_waddr = init_addr_q;
            ram_wdata = 8'h00;
            init_addr_d = init_addr_q + 11'h001;
            if (init_addr_q == 11'h7FF) begin
               init_pend_d = init_req;
               init_done_d = 1'b1;
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // Reconfiguration timer
   // ----------------------------------------------------------------------
   // Timeout length chosen by the two-bit field, restarted on request
   always_comb begin
      case (setup_q[1:0])
         2'b00: rc_limit = 28'(TO_00);
         2'b01: rc_limit = 28'(TO_01);
         2'b10: rc_limit = 28'(TO_10);
         default: rc_limit = 28'(TO_11);
      endcase
      // Count from the start pulse; the timeout flag lasts a single cycle
      rc_cnt_d = rc_cnt_q;
      rc_run_d = rc_run_q;
      rc_to_d = 1'b0;
      if (reconfig_start) begin
         rc_cnt_d = '0;
         rc_run_d = 1'b1;
      end else if (rc_run_q) begin
         if (rc_cnt_q >= rc_limit - 28'h000_0001) begin
            rc_to_d = 1'b1;
            rc_run_d = 1'b0;
         end else begin
            rc_cnt_d = rc_cnt_q + 28'h000_0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // Host registers and the prefetch/post path; all freeze while clk_en is low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         setup_q <= `SETUP_RESET;
         autoinc_q <= 1'b0;
         hi_q <= 3'h0;
         ptr_q <= '0;
         hold_q <= 8'h00;
         wbuf_q <= 8'h00;
         fetch_pend_q <= 1'b0;
         store_pend_q <= 1'b0;
         store_addr_q <= '0;
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         setup_q <= setup_d;
         autoinc_q <= autoinc_d;
         hi_q <= hi_d;
         ptr_q <= ptr_d;
         hold_q <= hold_d;
         wbuf_q <= wbuf_d;
         fetch_pend_q <= fetch_pend_d;
         store_pend_q <= store_pend_d;
         store_addr_q <= store_addr_d;
         rdata_q <= rdata_d;
      end
   end

   // Engine state; the tick restarts high so the first grant is not delayed
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arb_tick_q <= 1'b1;
         st_q <= ST_IDLE;
         init_pend_q <= 1'b0;
         init_addr_q <= '0;
         init_done_q <= 1'b0;
      end else if (clk_en) begin
         arb_tick_q <= arb_tick_d;
         st_q <= st_d;
         init_pend_q <= init_pend_d;
         init_addr_q <= init_addr_d;
         init_done_q <= init_done_d;
      end
   end

   // Reconfiguration timer; a held-off clock enable stretches the timeout too
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rc_cnt_q <= '0;
         rc_run_q <= 1'b0;
         rc_to_q <= 1'b0;
      end else if (clk_en) begin
         rc_cnt_q <= rc_cnt_d;
         rc_run_q <= rc_run_d;
         rc_to_q <= rc_to_d;
      end
   end

   // Buffer memory has no reset; contents are set by the init sweep.
   // Until the first sweep a prefetch may return unknown bytes.
   always_ff @(posedge clk) begin
      if (clk_en && ram_we) begin
         ram[ram_waddr] <= ram_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Enhanced bit is exported; legacy behaviour is the default when clear
   assign host_rdata = rdata_q;
   assign setup_out = {setup_q[`SETUP_FAST_READ_BIT], setup_q[`SETUP_ENH_BIT],
                       setup_q[`SETUP_SKIP_BIT], setup_q[1:0]};
   assign fast_read_out = setup_q[`SETUP_FAST_READ_BIT];

   // Status flags, each straight from its flop
   assign init_done = init_done_q;
   assign reconfig_timeout = rc_to_q;
   assign busy = fetch_pend_q;

endmodule
